// [src/ceac_pkg.sv]
// Purpose: shared constants of the configuration eeprom access controller
// Assumes: byte-wide register accesses at the printed byte addresses
// Notes: command codes and field positions of the control/status word
package ceac_pkg;
  localparam logic [11:0] ADDR_CFG = 12'h500;
  localparam logic [11:0] ADDR_ACC = 12'h501;
  localparam logic [11:0] ADDR_CTL_LO = 12'h502;
  localparam logic [11:0] ADDR_CTL_HI = 12'h503;
  localparam logic [11:0] ADDR_ADR0 = 12'h504;
  localparam logic [11:0] ADDR_DAT0 = 12'h508;
  localparam logic [11:0] ADDR_DAT1 = 12'h509;
  localparam int CFG_OFFER = 0;
  localparam int CFG_FORCE = 1;
  localparam int ACC_TAKEN = 0;
  localparam int CTL_WE = 0;
  localparam int CTL_EMU = 5;
  localparam int CTL_RD8 = 6;
  localparam int CTL_ADR2 = 7;
  localparam int HI_CSUM = 3;
  localparam int HI_LOAD = 4;
  localparam int HI_ERR_ACK = 5;
  localparam int HI_ERR_WE = 6;
  localparam int HI_BUSY = 7;
  localparam logic [2:0] CMD_IDLE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_RELOAD = 3'h4;
  localparam logic [31:0] ADDR_MASK_SMALL = 32'h0000_03ff;
  localparam logic [31:0] ADDR_MASK_LARGE = 32'h0003_ffff;
  localparam logic [63:0] RD4_MASK = 64'h0000_0000_ffff_ffff;
endpackage : ceac_pkg

// [src/ceac_ctrl.sv]
// Purpose: eeprom ownership, command, status and data registers of the slave controller
// Assumes: one byte access per side per cycle; read data shows one cycle after the address
// Notes: bit-level i2c is done outside; this block hands it one request per command in normal mode
// Operation
// [RQ1] master-only bit offers eeprom to host
// [RQ2] force bit set clears host access bit
// [RQ3] host access writes only when offered, unforced
// [RQ4] write enable reads one under host ownership
// [RQ5] master write enable clears at frame start
// [RQ6] commands: idle, read, write, reload
// [RQ7] command field shows running command, then 000
// [RQ8] command writes ignored while ack error set
// [RQ9] idle or valid command clears error bits
// [RQ10] nack or invalid command sets ack error
// [RQ11] write without enable sets error, no write
// [RQ12] busy bit reflects running operation
// [RQ13] busy blocks control, address, data writes
// [RQ14] status bit reports four or eight bytes
// [RQ15] status bit reports address byte count
// [RQ16] word address masked by eeprom size
// [RQ17] status bit reports emulation mode
// [RQ18] emulating host acknowledges by writing command
// [RQ19] host acknowledge clears event request
// [RQ20] emulating host fills data on read/reload
// [RQ21] data low word writable, upper read-only
// [RQ22] loading and checksum status bits
// [RQ23] normal mode issues i2c transactions
`timescale 1ns/10ps
module ceac_ctrl
  import ceac_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic fm_wr_in,
  input wire logic [11:0] fm_addr_in,
  input wire logic [7:0] fm_wdata_in,
  output logic [7:0] fm_rdata_out,
  input wire logic lh_wr_in,
  input wire logic [11:0] lh_addr_in,
  input wire logic [7:0] lh_wdata_in,
  output logic [7:0] lh_rdata_out,
  input wire logic sof_in,
  input wire logic emu_strap_in,
  input wire logic rd8_strap_in,
  input wire logic addr2_strap_in,
  input wire logic load_done_in,
  input wire logic csum_err_in,
  output logic i2c_req_out,
  output logic [2:0] i2c_cmd_out,
  output logic i2c_addr2_out,
  output logic [31:0] i2c_addr_out,
  output logic [15:0] i2c_wdata_out,
  input wire logic i2c_done_in,
  input wire logic i2c_nack_in,
  input wire logic [63:0] i2c_rdata_in,
  output logic app_layer_event_request_out
);

  typedef struct packed {
    logic offer;
    logic force_m;
    logic host_acc;
    logic we;
    logic [2:0] cmd;
    logic err_ack;
    logic err_we;
    logic busy;
    logic emu;
    logic rd8;
    logic addr2;
    logic loaded;
    logic csum;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0] fm_rdata;
    logic [7:0] lh_rdata;
    logic i2c_req;
    logic [2:0] i2c_cmd;
    logic [31:0] i2c_addr;
    logic [15:0] i2c_wdata;
    logic ev_req;
  } ceac_state_t;

  ceac_state_t s;
  ceac_state_t next_s;
  logic host_owns;
  logic own_wr;
  logic [11:0] own_addr;
  logic [7:0] own_wdata;

  // read view of the register window, shared by both access ports
  function automatic logic [7:0] ceac_reg_byte(input ceac_state_t st, input logic [11:0] a, input logic owns);
    logic [7:0] b;
    b = 8'h00;
    if (a == ADDR_CFG) begin
      b[CFG_OFFER] = st.offer;
      b[CFG_FORCE] = st.force_m;
    end else if (a == ADDR_ACC) begin
      b[ACC_TAKEN] = st.host_acc;
    end else if (a == ADDR_CTL_LO) begin
      b[CTL_WE] = st.we | owns; // [RQ4]
      b[CTL_EMU] = st.emu; // [RQ17]
      b[CTL_RD8] = st.rd8; // [RQ14]
      b[CTL_ADR2] = st.addr2; // [RQ15]
    end else if (a == ADDR_CTL_HI) begin
      b[2:0] = st.cmd; // [RQ7]
      b[HI_CSUM] = st.csum; // [RQ22]
      b[HI_LOAD] = ~st.loaded; // [RQ22]
      b[HI_ERR_ACK] = st.err_ack;
      b[HI_ERR_WE] = st.err_we;
      b[HI_BUSY] = st.busy; // [RQ12]
    end else if (a[11:2] == ADDR_ADR0[11:2]) begin
      b = st.addr[{a[1:0], 3'h0} +: 8];
    end else if (a[11:3] == ADDR_DAT0[11:3]) begin
      b = st.data[{a[2:0], 3'h0} +: 8];
    end
    return b;
  endfunction : ceac_reg_byte

  // the owning side is the only one whose ordinary writes land
  assign host_owns = s.offer & s.host_acc; // [RQ1]
  assign own_wr = host_owns ? lh_wr_in : fm_wr_in;
  assign own_addr = host_owns ? lh_addr_in : fm_addr_in;
  assign own_wdata = host_owns ? lh_wdata_in : fm_wdata_in;

  // next-state logic; later assignments win, so a write enable write beats the frame-start clear in the same cycle
  always_comb begin
    next_s = s;
    next_s.i2c_req = 1'b0;
    next_s.loaded = load_done_in;
    next_s.csum = csum_err_in;
    if (sof_in) begin
      next_s.we = 1'b0; // [RQ5]
    end
    // host take/release only while offered and not forced
    if (lh_wr_in && lh_addr_in == ADDR_ACC && s.offer && !s.force_m) begin
      next_s.host_acc = lh_wdata_in[ACC_TAKEN]; // [RQ3]
    end
    // configuration byte is master-only; it comes after the host take so a force in the same cycle wins
    if (fm_wr_in && fm_addr_in == ADDR_CFG) begin
      next_s.offer = fm_wdata_in[CFG_OFFER]; // [RQ1]
      next_s.force_m = fm_wdata_in[CFG_FORCE];
      if (fm_wdata_in[CFG_FORCE]) begin
        next_s.host_acc = 1'b0; // [RQ2]
      end
    end
    // ordinary owner writes, all blocked while busy
    if (own_wr && !s.busy) begin // [RQ13]
      if (own_addr == ADDR_CTL_LO && !host_owns) begin
        next_s.we = own_wdata[CTL_WE];
      end else if (own_addr == ADDR_CTL_HI) begin
        if (own_wdata[2:0] == CMD_IDLE) begin
          next_s.err_ack = 1'b0; // [RQ9]
          next_s.err_we = 1'b0;
        end else if (!s.err_ack) begin // [RQ8]
          if (own_wdata[2:0] == CMD_READ || own_wdata[2:0] == CMD_WRITE || own_wdata[2:0] == CMD_RELOAD) begin
            next_s.err_ack = 1'b0; // [RQ9]
            next_s.err_we = 1'b0;
            if (own_wdata[2:0] == CMD_WRITE && !(s.we | host_owns)) begin
              next_s.err_we = 1'b1; // [RQ11]
            end else begin
              next_s.cmd = own_wdata[2:0]; // [RQ6]
              next_s.busy = 1'b1; // [RQ12]
              if (s.emu) begin
                next_s.ev_req = 1'b1;
              end else begin
                next_s.i2c_req = 1'b1; // [RQ23]
                next_s.i2c_cmd = own_wdata[2:0];
                next_s.i2c_addr = s.addr & (s.addr2 ? ADDR_MASK_LARGE : ADDR_MASK_SMALL); // [RQ16]
                next_s.i2c_wdata = s.data[15:0];
              end
            end
          end else begin
            next_s.err_ack = 1'b1; // [RQ10]
          end
        end
      end else if (own_addr[11:2] == ADDR_ADR0[11:2]) begin
        next_s.addr[{own_addr[1:0], 3'h0} +: 8] = own_wdata; // [RQ16]
      end else if (own_addr == ADDR_DAT0 || own_addr == ADDR_DAT1) begin
        next_s.data[{own_addr[2:0], 3'h0} +: 8] = own_wdata; // [RQ21]
      end
    end
    // emulating host serves the pending command while busy
    if (s.emu && s.busy && lh_wr_in) begin
      if (lh_addr_in == ADDR_CTL_HI && lh_wdata_in[2:0] == s.cmd) begin
        next_s.busy = 1'b0; // [RQ18]
        next_s.cmd = CMD_IDLE; // [RQ7]
        next_s.err_ack = lh_wdata_in[HI_ERR_ACK];
        next_s.ev_req = 1'b0; // [RQ19]
      end else if (lh_addr_in[11:3] == ADDR_DAT0[11:3] && (s.cmd == CMD_READ || s.cmd == CMD_RELOAD)) begin
        next_s.data[{lh_addr_in[2:0], 3'h0} +: 8] = lh_wdata_in; // [RQ20]
      end
    end
    // i2c engine completion in normal mode
    if (!s.emu && s.busy && i2c_done_in) begin
      next_s.busy = 1'b0; // [RQ12]
      next_s.cmd = CMD_IDLE; // [RQ7]
      next_s.err_ack = i2c_nack_in; // [RQ10]
      if (s.cmd == CMD_READ && !i2c_nack_in) begin
        next_s.data = s.rd8 ? i2c_rdata_in : (i2c_rdata_in & RD4_MASK); // [RQ14]
      end
    end
    next_s.fm_rdata = ceac_reg_byte(s, fm_addr_in, host_owns);
    next_s.lh_rdata = ceac_reg_byte(s, lh_addr_in, host_owns);
  end

  // single state register; straps are caught while reset is held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.emu <= emu_strap_in;
      s.rd8 <= rd8_strap_in;
      s.addr2 <= addr2_strap_in;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign fm_rdata_out = s.fm_rdata;
  assign lh_rdata_out = s.lh_rdata;
  assign i2c_req_out = s.i2c_req;
  assign i2c_cmd_out = s.i2c_cmd;
  assign i2c_addr2_out = s.addr2;
  assign i2c_addr_out = s.i2c_addr;
  assign i2c_wdata_out = s.i2c_wdata;
  assign app_layer_event_request_out = s.ev_req;

  // a command start as taken by the owner write path
  sequence cmd_start_s;
    own_wr && !s.busy && !s.err_ack && own_addr == ADDR_CTL_HI && own_wdata[2:0] != CMD_IDLE;
  endsequence

  sequence busy_end_s;
    s.busy ##1 !s.busy;
  endsequence

  force_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ2]
    fm_wr_in && fm_addr_in == ADDR_CFG && fm_wdata_in[CFG_FORCE] |=> !s.host_acc)
    else $error("force bit did not clear host access");

  access_guard_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ3]
    lh_wr_in && lh_addr_in == ADDR_ACC && !(s.offer && !s.force_m) && !(fm_wr_in && fm_addr_in == ADDR_CFG)
    |=> $stable(s.host_acc))
    else $error("host access changed while not offered");

  we_host_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ4]
    host_owns && fm_addr_in == ADDR_CTL_LO |=> fm_rdata_out[CTL_WE])
    else $error("write enable not shown as one under host ownership");

  we_sof_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ5]
    sof_in && !(fm_wr_in && fm_addr_in == ADDR_CTL_LO) |=> !s.we)
    else $error("write enable survived frame start");

  cmd_idle_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ7]
    busy_end_s |-> s.cmd == CMD_IDLE)
    else $error("command field not idle after busy ends");

  err_ignore_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ8]
    own_wr && !s.busy && s.err_ack && own_addr == ADDR_CTL_HI && own_wdata[2:0] != CMD_IDLE
    && !(s.emu && s.busy) |=> !s.busy && s.err_ack)
    else $error("command accepted while ack error pending");

  we_err_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ11]
    cmd_start_s and (own_wdata[2:0] == CMD_WRITE && !(s.we | host_owns)) |=> s.err_we && !s.busy)
    else $error("write without enable not flagged");

  busy_block_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ13]
    s.busy |=> $stable(s.addr))
    else $error("address changed while busy");

  emu_ack_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ19]
    s.emu && s.busy && lh_wr_in && lh_addr_in == ADDR_CTL_HI && lh_wdata_in[2:0] == s.cmd
    |=> !s.busy && !app_layer_event_request_out)
    else $error("emulation acknowledge did not finish command");

  i2c_start_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ23]
    cmd_start_s and (!s.emu && (own_wdata[2:0] == CMD_READ || own_wdata[2:0] == CMD_RELOAD))
    |=> i2c_req_out && s.busy ##1 !i2c_req_out)
    else $error("normal-mode command did not issue one i2c request");

  // an idle command written while not busy wipes both error flags
  err_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ9]
    own_wr && !s.busy && own_addr == ADDR_CTL_HI && own_wdata[2:0] == CMD_IDLE |=> !s.err_ack && !s.err_we)
    else $error("idle command did not clear error flags");

  // a reserved code raises the ack error and never starts anything
  bad_cmd_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ10]
    own_wr && !s.busy && !s.err_ack && own_addr == ADDR_CTL_HI && own_wdata[2:0] != CMD_IDLE
    && own_wdata[2:0] != CMD_READ && own_wdata[2:0] != CMD_WRITE && own_wdata[2:0] != CMD_RELOAD
    |=> s.err_ack && !s.busy)
    else $error("invalid command not flagged");

  // with no command running only the two low data bytes may take a write
  data_upper_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ21]
    !s.busy && !(own_wr && (own_addr == ADDR_DAT0 || own_addr == ADDR_DAT1)) |=> $stable(s.data))
    else $error("data register changed without a permitted write");

  // four-byte parts must leave the upper half of the read word clear
  rd4_load_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ14]
    !s.emu && !s.rd8 && s.busy && s.cmd == CMD_READ && i2c_done_in && !i2c_nack_in |=> (s.data & ~RD4_MASK) == '0)
    else $error("four-byte read loaded upper bytes");

  // the engine never sees address bits beyond the selected part size
  addr_mask_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ16]
    i2c_req_out |-> (i2c_addr_out & ~(s.addr2 ? ADDR_MASK_LARGE : ADDR_MASK_SMALL)) == '0)
    else $error("word address not masked to part size");

endmodule : ceac_ctrl

// [tb/ceac_eeprom_model.sv]
// Purpose: behavioural i2c eeprom engine that answers the controller's requests
// Assumes: one request outstanding at a time; lat_in of at least one cycle
// Notes: read bus inverts itself every cycle between answers, so the last answer reappears every other cycle
`timescale 1ns/10ps
module ceac_eeprom_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic nack_sel_in,
  input wire logic [3:0] lat_in,
  input wire logic [63:0] word_in,
  output logic done_out,
  output logic nack_out,
  output logic [63:0] rdata_out
);
  logic [3:0] cnt;
  // count the answer delay down, then pulse done with data or nack
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    nack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (rst_in) begin
      cnt <= 4'h0;
      rdata_out <= 64'h0;
    end else if (req_in) begin
      cnt <= lat_in;
    end else if (cnt == 4'h1) begin
      cnt <= 4'h0;
      done_out <= 1'b1;
      nack_out <= nack_sel_in;
      rdata_out <= word_in;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : ceac_eeprom_model

// [tb/tb_config_eeprom_access_ctrl.sv]
// Purpose: self-checking bench of the eeprom access controller
// Assumes: byte accesses, rdata one cycle after the address
// Notes: second reset switches the straps into emulation mode
`timescale 1ns/10ps
module tb_config_eeprom_access_ctrl;
  import ceac_pkg::*;
  logic clk_in = 0, rst_in = 1, fm_wr_in = 0, lh_wr_in = 0, sof_in = 0, emu = 0, rd8 = 1, a2 = 0;
  logic ld = 0, cs = 1, req, a2o, done, nack, nsel = 0, ev;
  logic [11:0] fm_addr_in = 0, lh_addr_in = 0;
  logic [7:0] fm_wdata_in = 0, lh_wdata_in = 0, fm_rdata_out, lh_rdata_out;
  logic [2:0] cmd;
  logic [31:0] adr, ea;
  logic [15:0] wd, wdo;
  logic [63:0] rdat, word = 0;
  logic [3:0] lat = 4'h1;
  int miscompares = 0, samples_checked = 0;
  ceac_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .fm_wr_in(fm_wr_in), .fm_addr_in(fm_addr_in),
    .fm_wdata_in(fm_wdata_in), .fm_rdata_out(fm_rdata_out), .lh_wr_in(lh_wr_in), .lh_addr_in(lh_addr_in),
    .lh_wdata_in(lh_wdata_in), .lh_rdata_out(lh_rdata_out), .sof_in(sof_in), .emu_strap_in(emu),
    .rd8_strap_in(rd8), .addr2_strap_in(a2), .load_done_in(ld), .csum_err_in(cs), .i2c_req_out(req),
    .i2c_cmd_out(cmd), .i2c_addr2_out(a2o), .i2c_addr_out(adr), .i2c_wdata_out(wdo), .i2c_done_in(done),
    .i2c_nack_in(nack), .i2c_rdata_in(rdat), .app_layer_event_request_out(ev));
  ceac_eeprom_model MEM (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .nack_sel_in(nsel),
    .lat_in(lat), .word_in(word), .done_out(done), .nack_out(nack), .rdata_out(rdat));
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  task automatic summarize;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // about 250 cycles expected; cut a hang at 3000
  initial begin
    #300000;
    miscompares++;
    summarize();
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one byte write, held up to and over its taking edge
  task automatic wr(input logic h, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in); #1;
    if (h) {lh_wr_in, lh_addr_in, lh_wdata_in} = {1'b1, a, d};
    else {fm_wr_in, fm_addr_in, fm_wdata_in} = {1'b1, a, d};
    @(posedge clk_in); #1;
    fm_wr_in = 0;
    lh_wr_in = 0;
  endtask : wr
  task automatic rd(input logic h, input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_in); #1;
    if (h) lh_addr_in = a;
    else fm_addr_in = a;
    @(posedge clk_in); #1;
    chk(64'(h ? lh_rdata_out : fm_rdata_out), 64'(e));
  endtask : rd
  // wait for the engine answer, bounded
  task automatic fin;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk_in); #1;
      n++;
    end
    @(posedge clk_in); #1;
  endtask : fin
  task automatic rs(input logic e, input logic r, input logic b);
    {rst_in, emu, rd8, a2} = {1'b1, e, r, b};
    repeat (20) @(posedge clk_in);
    #1 rst_in = 0;
  endtask : rs
  function automatic logic [7:0] hi(input logic [2:0] c, input logic k, input logic w, input logic b);
    return {b, w, k, ~ld, cs, c};
  endfunction : hi
  function automatic logic [7:0] lo(input logic w);
    return {a2, rd8, emu, 4'h0, w};
  endfunction : lo
  initial begin
    void'($urandom(32'h9b870ed0));
    rs(0, 1, 0);
    rd(0, ADDR_CTL_LO, lo(0));
    rd(0, ADDR_CTL_HI, hi(0, 0, 0, 0));
    {ld, cs} = 2'b10;
    rd(0, ADDR_CTL_HI, hi(0, 0, 0, 0));
    wr(1, ADDR_ACC, 8'h01);
    rd(1, ADDR_ACC, 8'h00);
    wr(0, ADDR_CFG, 8'h01);
    wr(1, ADDR_CFG, 8'h00);
    rd(0, ADDR_CFG, 8'h01);
    wr(1, ADDR_ACC, 8'h01);
    rd(1, ADDR_CTL_LO, lo(1));
    wr(0, ADDR_CFG, 8'h03);
    rd(1, ADDR_ACC, 8'h00);
    wr(1, ADDR_ACC, 8'h01);
    rd(1, ADDR_ACC, 8'h00);
    wr(0, ADDR_CFG, 8'h00);
    wr(0, ADDR_CTL_HI, 8'h03);
    rd(0, ADDR_CTL_HI, hi(0, 1, 0, 0));
    wr(0, ADDR_CTL_HI, 8'h01);
    chk(64'(req), 64'(0));
    wr(0, ADDR_CTL_HI, 8'h00);
    wr(0, ADDR_CTL_HI, 8'h02);
    chk(64'(req), 64'(0));
    rd(0, ADDR_CTL_HI, hi(0, 0, 1, 0));
    wr(0, ADDR_CTL_LO, 8'h01);
    sof_in = 1;
    @(posedge clk_in); #1;
    sof_in = 0;
    rd(0, ADDR_CTL_LO, lo(0));
    ea = $urandom;
    wd = 16'($urandom);
    for (int i = 0; i < 4; i++) wr(0, ADDR_ADR0 + 12'(i), ea[8*i +: 8]);
    wr(0, ADDR_DAT0, wd[7:0]);
    wr(0, ADDR_DAT1, wd[15:8]);
    wr(0, ADDR_CTL_LO, 8'h01);
    lat = 4'h8;
    wr(0, ADDR_CTL_HI, 8'h02);
    chk(64'({req, cmd, adr, wdo}), 64'({1'b1, CMD_WRITE, ea & ADDR_MASK_SMALL, wd}));
    wr(0, ADDR_ADR0, ~ea[7:0]);
    rd(0, ADDR_CTL_HI, hi(CMD_WRITE, 0, 0, 1));
    fin();
    rd(0, ADDR_ADR0, ea[7:0]);
    rd(0, ADDR_CTL_HI, hi(0, 0, 0, 0));
    {nsel, lat, word} = {1'b1, 4'h1, $urandom, $urandom};
    wr(0, ADDR_CTL_HI, 8'h01);
    fin();
    rd(0, ADDR_CTL_HI, hi(0, 1, 0, 0));
    wr(0, ADDR_CTL_HI, 8'h00);
    nsel = 0;
    wr(0, ADDR_CTL_HI, 8'h01);
    chk(64'({req, cmd}), 64'({1'b1, CMD_READ}));
    fin();
    wr(0, ADDR_DAT0 + 12'h2, ~word[23:16]);
    for (int i = 0; i < 8; i++) rd(0, ADDR_DAT0 + 12'(i), word[8*i +: 8]);
    wr(0, ADDR_CTL_HI, 8'h04);
    chk(64'({req, cmd}), 64'({1'b1, CMD_RELOAD}));
    fin();
    rs(1, 0, 1);
    chk(64'(a2o), 64'(1));
    rd(0, ADDR_CTL_LO, lo(0));
    wr(0, ADDR_CTL_HI, 8'h01);
    chk(64'({ev, req}), 64'(2'b10));
    for (int i = 0; i < 4; i++) wr(1, ADDR_DAT0 + 12'(i), ~word[8*i +: 8]);
    wr(1, ADDR_CTL_HI, 8'h01);
    chk(64'(ev), 64'(0));
    rd(0, ADDR_CTL_HI, hi(0, 0, 0, 0));
    for (int i = 0; i < 4; i++) rd(0, ADDR_DAT0 + 12'(i), ~word[8*i +: 8]);
    // emulating host reports a temporary failure while acknowledging a reload
    wr(0, ADDR_CTL_HI, 8'h04);
    wr(1, ADDR_CTL_HI, 8'h24);
    rd(0, ADDR_CTL_HI, hi(0, 1, 0, 0));
    // normal mode with four read bytes and two address bytes
    rs(0, 0, 1);
    ea = $urandom;
    {lat, word} = {4'($urandom_range(1, 15)), $urandom, $urandom};
    for (int i = 0; i < 4; i++) wr(0, ADDR_ADR0 + 12'(i), ea[8*i +: 8]);
    wr(0, ADDR_CTL_HI, 8'h01);
    chk(64'({req, cmd, adr}), 64'({1'b1, CMD_READ, ea & ADDR_MASK_LARGE}));
    fin();
    for (int i = 0; i < 8; i++) rd(0, ADDR_DAT0 + 12'(i), i < 4 ? word[8*i +: 8] : 8'h00);
    summarize();
  end
endmodule : tb_config_eeprom_access_ctrl
